// ===== design/sscc_pkg.sv
/*
 * Constants for the stereo sound chip configuration block: register
 * offset, field positions, location codes and page addresses.
 * Assumes a 16-bit host address bus and an 8-bit host data bus.
 */
package sscc_pkg;

    localparam logic [15:0] CFG_ADDR        = 16'hD0F4;
    localparam logic [7:0]  CFG_RESET       = 8'h00;

    localparam int          FILT_SECOND_BIT = 7;
    localparam int          FILT_FIRST_BIT  = 6;
    localparam int          PHYS_LSB        = 3;
    localparam int          EMU_LSB         = 0;

    // Physical second chip location codes
    localparam logic [2:0]  PHYS_SINGLE     = 3'h0;
    localparam logic [2:0]  PHYS_D420       = 3'h1;
    localparam logic [2:0]  PHYS_D500       = 3'h4;
    localparam logic [2:0]  PHYS_D700       = 3'h5;
    localparam logic [2:0]  PHYS_DE00       = 3'h6;
    localparam logic [2:0]  PHYS_DF00       = 3'h7;

    // Emulated stereo decode codes
    localparam logic [2:0]  EMU_SINGLE      = 3'h0;
    localparam logic [2:0]  EMU_A5          = 3'h1;
    localparam logic [2:0]  EMU_A8          = 3'h4;
    localparam logic [2:0]  EMU_A8_ALT      = 3'h5;
    localparam logic [2:0]  EMU_IOLOW       = 3'h6;
    localparam logic [2:0]  EMU_IOHIGH      = 3'h7;

    localparam logic [15:0] BASE_FIRST      = 16'hD400;
    localparam logic [15:0] BASE_D420       = 16'hD420;
    localparam logic [15:0] BASE_D500       = 16'hD500;
    localparam logic [15:0] BASE_D700       = 16'hD700;
    localparam logic [15:0] BASE_DE00       = 16'hDE00;
    localparam logic [15:0] BASE_DF00       = 16'hDF00;
    localparam logic [7:0]  PAGE_D4         = 8'hD4;
    localparam logic [7:0]  PAGE_D5         = 8'hD5;
    localparam logic [7:0]  PAGE_D7         = 8'hD7;
    localparam logic [7:0]  PAGE_DE         = 8'hDE;
    localparam logic [7:0]  PAGE_DF         = 8'hDF;
    localparam logic [15:0] CHIP_MASK       = 16'h001F;

    localparam logic [1:0]  TGT_NONE        = 2'h0;
    localparam logic [1:0]  TGT_FIRST       = 2'h1;
    localparam logic [1:0]  TGT_SECOND      = 2'h2;

endpackage

// ===== design/sscc_decode.sv
/*
 * Combinational decode of one host access against the configuration:
 * which emulated chip (if any) it hits, and where the physical copy is.
 * Assumes address and config are stable in the cycle they are read.
 */
`timescale 1ns/1ps
`default_nettype none

module sscc_decode (
    input  wire logic [15:0] addr_i,
    input  wire logic [2:0]  emu_code_i,
    input  wire logic [2:0]  phys_code_i,
    input  wire logic        cart_low_i,
    input  wire logic        cart_high_i,
    output logic      [1:0]  target_o,
    output logic             stereo_o,
    output logic             phys_two_o,
    output logic      [15:0] phys_base_o
);

    logic [7:0] page;
    assign page = addr_i[15:8];

    always_comb begin
        stereo_o = 1'b1;
        target_o = sscc_pkg::TGT_NONE;
        // First chip decodes across its page unless the stereo decode claims the copy
        if (page == sscc_pkg::PAGE_D4) begin
            target_o = sscc_pkg::TGT_FIRST;
        end
        case (emu_code_i)
            sscc_pkg::EMU_A5: begin
                if (page == sscc_pkg::PAGE_D4 && addr_i[5]) begin
                    target_o = sscc_pkg::TGT_SECOND;
                end
            end
            sscc_pkg::EMU_A8, sscc_pkg::EMU_A8_ALT: begin
                if ((page == sscc_pkg::PAGE_D5) || (page == sscc_pkg::PAGE_D7)) begin
                    target_o = sscc_pkg::TGT_SECOND;
                end
            end
            sscc_pkg::EMU_IOLOW: begin
                if (page == sscc_pkg::PAGE_DE && !cart_low_i) begin
                    target_o = sscc_pkg::TGT_SECOND;
                end
            end
            sscc_pkg::EMU_IOHIGH: begin
                if (page == sscc_pkg::PAGE_DF && !cart_high_i) begin
                    target_o = sscc_pkg::TGT_SECOND;
                end
            end
            default: begin
                stereo_o = 1'b0;
            end
        endcase
    end

    always_comb begin
        phys_two_o  = 1'b1;
        case (phys_code_i)
            sscc_pkg::PHYS_D420: phys_base_o = sscc_pkg::BASE_D420;
            sscc_pkg::PHYS_D500: phys_base_o = sscc_pkg::BASE_D500;
            sscc_pkg::PHYS_D700: phys_base_o = sscc_pkg::BASE_D700;
            sscc_pkg::PHYS_DE00: phys_base_o = sscc_pkg::BASE_DE00;
            sscc_pkg::PHYS_DF00: phys_base_o = sscc_pkg::BASE_DF00;
            default: begin
                phys_two_o  = 1'b0;
                phys_base_o = sscc_pkg::BASE_FIRST;
            end
        endcase
    end

endmodule // sscc_decode

`default_nettype wire

// ===== design/sscc_top.sv
/*
 * Stereo sound chip configuration: holds the configuration register,
 * decodes host writes to the emulated chips, and forwards them to the
 * physical chips in the host with address translation.
 * Assumes host bus signals are synchronous to core_clk_i; a write is a
 * one-cycle host_wr_i strobe with address and data valid in that cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Second emulated chip may sit at D420, D500, D700, DE00 or DF00.
// - Stereo with one physical chip: forward left writes only, withhold right ones.
// - Two physical chips: left writes go to first, right writes to second.
// - Physical second-chip address used only for driving it, translated from emulated.
// - Active cartridge emulation on DE00/DF00 page wins over second chip.
// - Each emulated chip has its own exponential or linear filter curve.
// - Bit 7 selects second chip filter, bit 6 first; 0 exponential, 1 linear.
// - Bits 5..3 give physical second chip location; other codes reserved.
// - Bits 2..0 select stereo decode: A5 copies in D4 page, A8 for D5/D7.
// - Code 110 decodes second chip on low I/O page, 111 on high page.
// - Single-chip emulation plays the one chip on both outputs as mono.
// - In stereo, first chip decodes at D400 and feeds left; second feeds right.
module sscc_top (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [15:0] host_addr_i,
    input  wire logic [7:0]  host_wdata_i,
    input  wire logic        host_wr_i,
    input  wire logic        host_rd_i,
    input  wire logic        io_page_select_low_i,
    input  wire logic        io_page_select_high_i,
    output logic      [7:0]  host_rdata_o,
    output logic             host_rvalid_o,
    output logic             filt_linear_first_o,
    output logic             filt_linear_second_o,
    output logic             mono_o,
    output logic             emu_wr_first_o,
    output logic             emu_wr_second_o,
    output logic      [4:0]  emu_reg_o,
    output logic      [7:0]  emu_data_o,
    output logic             phys_wr_o,
    output logic      [15:0] phys_addr_o,
    output logic      [7:0]  phys_data_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Configuration register

    logic [7:0]  cfg;
    logic        cfg_hit;

    assign cfg_hit = (host_addr_i == sscc_pkg::CFG_ADDR);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg <= sscc_pkg::CFG_RESET;
        end else if (host_wr_i && cfg_hit) begin
            cfg <= host_wdata_i;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            host_rdata_o  <= 8'h00;
            host_rvalid_o <= 1'b0;
        end else begin
            host_rvalid_o <= host_rd_i && cfg_hit;
            host_rdata_o  <= (host_rd_i && cfg_hit) ? cfg : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Filter selection per emulated chip

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            filt_linear_first_o  <= 1'b0;
            filt_linear_second_o <= 1'b0;
        end else begin
            filt_linear_first_o  <= cfg[sscc_pkg::FILT_FIRST_BIT];
            filt_linear_second_o <= cfg[sscc_pkg::FILT_SECOND_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    logic [1:0]  target;
    logic        stereo;
    logic        phys_two;
    logic [15:0] phys_base;

    sscc_decode u_decode (
        .addr_i      (host_addr_i),
        .emu_code_i  (cfg[sscc_pkg::EMU_LSB +: 3]),
        .phys_code_i (cfg[sscc_pkg::PHYS_LSB +: 3]),
        .cart_low_i  (io_page_select_low_i),
        .cart_high_i (io_page_select_high_i),
        .target_o    (target),
        .stereo_o    (stereo),
        .phys_two_o  (phys_two),
        .phys_base_o (phys_base)
    );

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            mono_o <= 1'b1;
        end else begin
            mono_o <= !stereo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Emulated chip write strobes

    logic wr_first;
    logic wr_second;

    assign wr_first  = host_wr_i && (target == sscc_pkg::TGT_FIRST);
    assign wr_second = host_wr_i && (target == sscc_pkg::TGT_SECOND);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            emu_wr_first_o  <= 1'b0;
            emu_wr_second_o <= 1'b0;
            emu_reg_o       <= 5'h00;
            emu_data_o      <= 8'h00;
        end else begin
            emu_wr_first_o  <= wr_first;
            emu_wr_second_o <= wr_second;
            if (wr_first || wr_second) begin
                emu_reg_o  <= host_addr_i[4:0];
                emu_data_o <= host_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Physical chip forwarding

    logic        fwd;
    logic [15:0] fwd_addr;

    always_comb begin
        fwd      = 1'b0;
        fwd_addr = sscc_pkg::BASE_FIRST | (host_addr_i & sscc_pkg::CHIP_MASK);
        if (wr_first) begin
            fwd = 1'b1;
        end else if (wr_second && phys_two) begin
            fwd      = 1'b1;
            fwd_addr = phys_base | (host_addr_i & sscc_pkg::CHIP_MASK);
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            phys_wr_o   <= 1'b0;
            phys_addr_o <= 16'h0000;
            phys_data_o <= 8'h00;
        end else begin
            phys_wr_o <= fwd;
            if (fwd) begin
                phys_addr_o <= fwd_addr;
                phys_data_o <= host_wdata_i;
            end
        end
    end

endmodule // sscc_top

`default_nettype wire

// ===== verif/sscc_monitor.sv
/* Assertions on the sscc_top ports.
   Bound to every sscc_top instance. */
`timescale 1ns/1ps
`default_nettype none
module sscc_monitor (
    input wire logic        core_clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] host_addr_i,
    input wire logic [7:0]  host_wdata_i,
    input wire logic        host_wr_i,
    input wire logic        host_rd_i,
    input wire logic        io_page_select_low_i,
    input wire logic        host_rvalid_o,
    input wire logic        filt_linear_first_o,
    input wire logic        filt_linear_second_o,
    input wire logic        mono_o,
    input wire logic        emu_wr_first_o,
    input wire logic        emu_wr_second_o,
    input wire logic [4:0]  emu_reg_o,
    input wire logic [7:0]  emu_data_o,
    input wire logic        phys_wr_o,
    input wire logic [15:0] phys_addr_o,
    input wire logic [7:0]  phys_data_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    wire cfg_hit = host_addr_i == sscc_pkg::CFG_ADDR;
    wire cfg_wr  = host_wr_i && cfg_hit;
    wire wd6     = host_wdata_i[6];
    wire wd7     = host_wdata_i[7];
    wire wd_mono = !(host_wdata_i[2:0] inside {3'h1, 3'h4, 3'h5, 3'h6, 3'h7});
    rd_answer_a: assert property (host_rd_i && cfg_hit |=> host_rvalid_o)
        else $error("config read not answered");
    rd_stray_a: assert property (!(host_rd_i && cfg_hit) |=> !host_rvalid_o)
        else $error("read answered without cause");
    filt_first_a: assert property (cfg_wr |=> ##1 filt_linear_first_o == $past(wd6, 2))
        else $error("first filter select wrong");
    filt_second_a: assert property (cfg_wr |=> ##1 filt_linear_second_o == $past(wd7, 2))
        else $error("second filter select wrong");
    mono_mode_a: assert property (cfg_wr |=> ##1 mono_o == $past(wd_mono, 2))
        else $error("mono level wrong");
    one_target_a: assert property (!(emu_wr_first_o && emu_wr_second_o))
        else $error("both chips written");
    left_fwd_a: assert property (emu_wr_first_o |-> phys_wr_o
        && phys_addr_o == (sscc_pkg::BASE_FIRST | {11'h000, emu_reg_o}))
        else $error("left write not forwarded");
    phys_cause_a: assert property (phys_wr_o |-> emu_wr_first_o || emu_wr_second_o)
        else $error("physical write without cause");
    right_xlate_a: assert property (emu_wr_second_o && phys_wr_o |-> phys_addr_o[4:0] ==
        emu_reg_o && phys_data_o == emu_data_o && phys_addr_o[15:5] != 11'h6A0)
        else $error("right write translated wrongly");
    cart_wins_a: assert property (host_wr_i && io_page_select_low_i
        && host_addr_i[15:8] == sscc_pkg::PAGE_DE |=> !emu_wr_second_o)
        else $error("second chip answered cartridge page");
    mono_left_a: assert property (host_wr_i && host_addr_i[15:8] == sscc_pkg::PAGE_D4
        && mono_o && !$past(cfg_wr) |=> emu_wr_first_o)
        else $error("mono write missed first chip");
endmodule // sscc_monitor
bind sscc_top sscc_monitor u_mon (.*);
`default_nettype wire

// ===== verif/sscc_phys_chips.sv
/* Two physical sound chips in the host, counting forwarded writes.
   Fed by the physical write port of sscc_top. */
`timescale 1ns/1ps
`default_nettype none
module sscc_phys_chips (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_i,
    input  wire logic [15:0] addr_i,
    output logic      [15:0] first_cnt_o,
    output logic      [15:0] second_cnt_o
);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            first_cnt_o  <= 16'h0000;
            second_cnt_o <= 16'h0000;
        end else if (wr_i && addr_i[15:5] == 11'h6A0) begin
            first_cnt_o <= first_cnt_o + 16'h0001;
        end else if (wr_i) begin
            second_cnt_o <= second_cnt_o + 16'h0001;
        end
    end
endmodule // sscc_phys_chips
`default_nettype wire

// ===== verif/sscc_tb_top.sv
/* Self-checking bench for sscc_top with two physical chips.
   Needs sscc_pkg, sscc_top and the checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module sscc_tb_top;
    logic        core_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0, rd = 1'b0, io_lo = 1'b0, io_hi = 1'b0;
    logic [7:0]  rdata, edata, pdata, cfg = 8'h00, ldata = 8'h00;
    logic        rvalid, f1, f2, mono, e1, e2, pwr;
    logic [4:0]  ereg, lreg = 5'h00;
    logic [15:0] paddr, c1, c2;
    logic [51:0] q[$];
    logic [7:0]  pages[5] = '{8'hD4, 8'hD5, 8'hD7, 8'hDE, 8'hDF};
    int          bad_count = 0, check_count = 0, n1 = 0, n2 = 0;
    always #5 core_clk_i = ~core_clk_i;
    sscc_top u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .host_addr_i(addr),
        .host_wdata_i(wdata), .host_wr_i(wr), .host_rd_i(rd), .io_page_select_low_i(io_lo),
        .io_page_select_high_i(io_hi), .host_rdata_o(rdata), .host_rvalid_o(rvalid),
        .filt_linear_first_o(f1), .filt_linear_second_o(f2), .mono_o(mono),
        .emu_wr_first_o(e1), .emu_wr_second_o(e2), .emu_reg_o(ereg), .emu_data_o(edata),
        .phys_wr_o(pwr), .phys_addr_o(paddr), .phys_data_o(pdata));
    sscc_phys_chips u_chips (.clk_i(core_clk_i), .rst_i(rst_i), .wr_i(pwr),
        .addr_i(paddr), .first_cnt_o(c1), .second_cnt_o(c2));
    function automatic logic [15:0] pbase(input logic [2:0] c);
        case (c)
            sscc_pkg::PHYS_D420: return sscc_pkg::BASE_D420;
            sscc_pkg::PHYS_D500: return sscc_pkg::BASE_D500;
            sscc_pkg::PHYS_D700: return sscc_pkg::BASE_D700;
            sscc_pkg::PHYS_DE00: return sscc_pkg::BASE_DE00;
            sscc_pkg::PHYS_DF00: return sscc_pkg::BASE_DF00;
            default: return 16'h0000;
        endcase
    endfunction
    task automatic chk(input logic [51:0] seen, input logic [51:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value result expected %h seen %h", exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Drives one access and notes the result it should produce
    task automatic op(input logic w, input logic r, input logic [15:0] a,
                      input logic [7:0] d);
        logic s, h1, h2, pw, rv;
        logic [15:0] pb;
        @(negedge core_clk_i);
        wr = w; rd = r; addr = a; wdata = d;
        io_lo = 1'($urandom); io_hi = 1'($urandom);
        s  = cfg[2:0] inside {3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
        h2 = w && ((cfg[2:0] == 3'h1 && a[15:8] == 8'hD4 && a[5])
            || (cfg[2:0] inside {3'h4, 3'h5} && a[15:8] inside {8'hD5, 8'hD7})
            || (cfg[2:0] == 3'h6 && a[15:8] == 8'hDE && !io_lo)
            || (cfg[2:0] == 3'h7 && a[15:8] == 8'hDF && !io_hi));
        h1 = w && a[15:8] == 8'hD4 && !h2;
        pb = pbase(cfg[5:3]);
        pw = h1 || (h2 && pb != 16'h0000);
        pb = h1 ? sscc_pkg::BASE_FIRST : pb;
        rv = r && a == sscc_pkg::CFG_ADDR;
        if (h1 || h2) begin
            lreg = a[4:0];
            ldata = d;
        end
        if (pw && h1) n1++;
        if (pw && !h1) n2++;
        if (rv || h1 || h2) q.push_back({rv, rv ? cfg : 8'h00, cfg[7:6], !s, h1, h2, lreg,
            ldata, pw, pw ? (pb | {11'h000, a[4:0]}) : 16'h0000, pw ? d : 8'h00});
        if (w && a == sscc_pkg::CFG_ADDR) cfg = d;
    endtask
    initial forever begin
        @(negedge core_clk_i);
        if (!rst_i && (rvalid | e1 | e2 | pwr) !== 1'b0)
            chk({rvalid, rdata, f2, f1, mono, e1, e2, ereg, edata, pwr,
                pwr ? paddr : 16'h0000, pwr ? pdata : 8'h00},
                q.size() > 0 ? q.pop_front() : 52'h0);
    end
    initial begin
        #200000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(41));
        repeat (5) @(posedge core_clk_i);
        @(negedge core_clk_i) rst_i = 1'b0;
        for (int i = 0; i < 64; i++) begin
            op(1'b1, 1'b0, sscc_pkg::CFG_ADDR, {2'($urandom), 6'(i)});
            op(1'b0, 1'b1, sscc_pkg::CFG_ADDR, 8'h00);
            op(1'b0, 1'b1, 16'($urandom), 8'h00);
            for (int p = 0; p < 5; p++)
                op(1'b1, 1'b0, {pages[p], 8'($urandom)}, 8'($urandom));
        end
        op(1'b0, 1'b0, 16'h0000, 8'h00);
        repeat (3) @(negedge core_clk_i);
        chk(52'(q.size()), 52'h0);
        chk({20'h0, c1, c2}, {20'h0, 16'(n1), 16'(n2)});
        tally_and_finish;
    end
endmodule // sscc_tb_top
`default_nettype wire
